// ### rtl/agm_circ.sv
// Circular buffer address correction for one address space
`timescale 1ns/1ps
module agm_circ #(
  parameter int unsigned AW = 16
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] step,
  input  wire logic          step_neg,
  input  wire logic [AW-1:0] buf_start,
  input  wire logic [AW-1:0] buf_end,
  input  wire logic          word_only,
  output      logic [AW-1:0] corrected
);
  logic [AW-1:0] span;
  logic [AW-1:0] raw;
  logic          pow2;

  assign span = AW'(buf_end - buf_start + AW'(1));
  assign pow2 = ((span & AW'(span - AW'(1))) == '0);

  // Beyond-limit test, so jumps past an edge are still folded back
  always_comb begin
    raw = addr;
    if ((step_neg || pow2) && addr < buf_start) begin
      raw = AW'(addr + span);
    end else if ((!step_neg || pow2) && addr > buf_end) begin
      raw = AW'(addr - span);
    end
    corrected = word_only ? (raw & {{(AW-1){1'b1}}, 1'b0}) : raw;
  end
endmodule : agm_circ

// ### rtl/agm_pkg.sv
// Package: register map, field layout, addressing modes and request carriers
package agm_pkg;
  localparam int unsigned ADDR_W = 16;

  // Register indices; the bus byte address is four times the index
  localparam logic [11:0] IDX_CORE_STATUS    = 12'h042;
  localparam logic [11:0] IDX_CORE_CONTROL   = 12'h044;
  localparam logic [11:0] IDX_CIRC_CONTROL   = 12'h046;
  localparam logic [11:0] IDX_X_BUF_START    = 12'h048;
  localparam logic [11:0] IDX_X_BUF_END      = 12'h04A;
  localparam logic [11:0] IDX_Y_BUF_START    = 12'h04C;
  localparam logic [11:0] IDX_Y_BUF_END      = 12'h04E;
  localparam logic [11:0] IDX_BITREV_MOD     = 12'h050;
  localparam logic [11:0] IDX_HOLD_COUNT     = 12'h052;
  localparam logic [11:0] IDX_BOOT_RAM_SEC   = 12'h750;
  localparam logic [11:0] IDX_SEC_RAM_SEC    = 12'h752;
  localparam logic [11:0] IDX_UNIT_STATUS    = 12'h754;

  localparam logic [15:0] RST_CORE_STATUS  = 16'h0000;
  localparam logic [15:0] RST_CORE_CONTROL = 16'h0020;
  localparam logic [15:0] RST_CIRC_CONTROL = 16'h0000;
  localparam logic [15:0] RST_START        = 16'h0000;
  localparam logic [15:0] RST_END          = 16'h0001;
  localparam logic [15:0] RST_ZERO         = 16'h0000;

  // Field positions
  localparam int unsigned XEN_BIT    = 15;
  localparam int unsigned YEN_BIT    = 14;
  localparam int unsigned BREV_BIT   = 15;
  localparam int unsigned XSEL_LSB   = 0;
  localparam int unsigned YSEL_LSB   = 4;
  localparam int unsigned BSEL_LSB   = 8;
  localparam logic [3:0]  SEL_OFF    = 4'hF;
  localparam logic [15:0] CIRC_WMASK = 16'hCFFF;
  localparam logic [15:0] HOLD_MASK  = 16'h3FFF;
  localparam logic [15:0] SEC_MASK   = 16'h0007;
  localparam logic [15:0] START_MASK = 16'hFFFE;
  localparam logic [15:0] END_SET    = 16'h0001;
  localparam logic [15:0] WORD_MASK  = 16'hFFFE;

  // Operand field widths
  localparam int unsigned FILE_ADDR_W = 13;
  localparam int unsigned LIT5_W      = 5;
  localparam int unsigned OFS_SEL_W   = 4;
  localparam int unsigned BRANCH_W    = 16;
  localparam int unsigned HOLD_LIT_W  = 14;
  localparam logic [15:0] MAX_CIRC_WORDS = 16'h8000;

  // Special pointer registers
  localparam logic [3:0] REG_DEFAULT = 4'h0;
  localparam logic [3:0] REG_WORK_8  = 4'h8;
  localparam logic [3:0] REG_WORK_9  = 4'h9;
  localparam logic [3:0] REG_WORK_10 = 4'hA;
  localparam logic [3:0] REG_WORK_11 = 4'hB;

  typedef enum logic [2:0] {
    AGM_MODE_FILE,
    AGM_MODE_IND,
    AGM_MODE_POST,
    AGM_MODE_PRE,
    AGM_MODE_REG_OFS,
    AGM_MODE_LIT_OFS,
    AGM_MODE_LIT5,
    AGM_MODE_DIRECT
  } agm_mode_t;

  typedef enum logic [1:0] {
    AGM_CLS_MCU,
    AGM_CLS_MOVE,
    AGM_CLS_MAC
  } agm_class_t;

  // Request from decoder: one operand address to compute
  typedef struct packed {
    logic        valid;
    agm_class_t  iclass;
    agm_mode_t   mode;
    logic        is_write;
    logic        prog_space;
    logic [3:0]  ptr_sel;
    logic [15:0] ptr_val;
    logic [15:0] ofs_val;
    logic [15:0] modifier;
    logic [12:0] file_addr;
    logic [4:0]  lit5;
  } agm_req_t;

  typedef struct packed {
    logic        valid;
    logic        illegal;
    logic        y_unit;
    logic        use_default;
    logic        is_literal;
    logic [15:0] ea;
    logic        wb_en;
    logic [3:0]  wb_sel;
    logic [15:0] wb_val;
  } agm_resp_t;
endpackage : agm_pkg

// ### rtl/agm_top.sv
// Address generation unit with circular buffers and APB register access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module agm_top #(
  parameter int unsigned AW = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output      logic [31:0]      prdata,
  output      logic             pready,
  output      logic             pslverr,
  input  wire agm_pkg::agm_req_t  req,
  output      agm_pkg::agm_resp_t resp,
  input  wire logic [15:0]      branch_literal,
  output      logic [AW-1:0]    branch_offset,
  input  wire logic             hold_load,
  input  wire logic [13:0]      hold_literal,
  output      logic             interrupts_held
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] core_status;
  logic [15:0] core_control;
  logic [15:0] circular_bitrev_control;
  logic [15:0] x_buffer_start;
  logic [15:0] x_buffer_end;
  logic [15:0] y_buffer_start;
  logic [15:0] y_buffer_end;
  logic [15:0] bit_reverse_modifier;
  logic [15:0] interrupt_disable_count;
  logic [15:0] boot_segment_ram_security;
  logic [15:0] secure_segment_ram_security;
  logic [15:0] unit_status;

  logic        apb_wr;
  logic        apb_rd;
  logic [11:0] idx;
  logic        hit;

  function automatic logic is_mapped(input logic [11:0] i);
    case (i)
      agm_pkg::IDX_CORE_STATUS, agm_pkg::IDX_CORE_CONTROL, agm_pkg::IDX_CIRC_CONTROL,
      agm_pkg::IDX_X_BUF_START, agm_pkg::IDX_X_BUF_END, agm_pkg::IDX_Y_BUF_START,
      agm_pkg::IDX_Y_BUF_END, agm_pkg::IDX_BITREV_MOD, agm_pkg::IDX_HOLD_COUNT,
      agm_pkg::IDX_BOOT_RAM_SEC, agm_pkg::IDX_SEC_RAM_SEC,
      agm_pkg::IDX_UNIT_STATUS: is_mapped = 1'b1;
      default:                  is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  // Byte address is four times the index; low two bits ignored
  assign idx     = paddr[13:2];
  assign hit     = is_mapped(idx) && (paddr[31:14] == '0);
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite && hit;
  assign apb_rd  = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !hit;

  function automatic logic wr_to(input logic [11:0] target);
    wr_to = apb_wr && (idx == target);
  endfunction : wr_to

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      core_status  <= agm_pkg::RST_CORE_STATUS;
      core_control <= agm_pkg::RST_CORE_CONTROL;
    end else begin
      if (wr_to(agm_pkg::IDX_CORE_STATUS))  core_status  <= pwdata[15:0];
      if (wr_to(agm_pkg::IDX_CORE_CONTROL)) core_control <= pwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      circular_bitrev_control <= agm_pkg::RST_CIRC_CONTROL;
      bit_reverse_modifier    <= agm_pkg::RST_ZERO;
    end else begin
      if (wr_to(agm_pkg::IDX_CIRC_CONTROL))
        circular_bitrev_control <= pwdata[15:0] & agm_pkg::CIRC_WMASK;
      if (wr_to(agm_pkg::IDX_BITREV_MOD)) bit_reverse_modifier <= pwdata[15:0];
    end
  end

  // Start forced even, end forced odd: length always whole words
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      x_buffer_start <= agm_pkg::RST_START;
      x_buffer_end   <= agm_pkg::RST_END;
      y_buffer_start <= agm_pkg::RST_START;
      y_buffer_end   <= agm_pkg::RST_END;
    end else begin
      if (wr_to(agm_pkg::IDX_X_BUF_START))
        x_buffer_start <= pwdata[15:0] & agm_pkg::START_MASK;
      if (wr_to(agm_pkg::IDX_X_BUF_END))
        x_buffer_end <= pwdata[15:0] | agm_pkg::END_SET;
      if (wr_to(agm_pkg::IDX_Y_BUF_START))
        y_buffer_start <= pwdata[15:0] & agm_pkg::START_MASK;
      if (wr_to(agm_pkg::IDX_Y_BUF_END))
        y_buffer_end <= pwdata[15:0] | agm_pkg::END_SET;
    end
  end

  // Count-down of interrupt hold; instruction load wins over a bus write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      interrupt_disable_count <= agm_pkg::RST_ZERO;
    end else if (hold_load) begin
      interrupt_disable_count <= {2'b00, hold_literal};
    end else if (wr_to(agm_pkg::IDX_HOLD_COUNT)) begin
      interrupt_disable_count <= pwdata[15:0] & agm_pkg::HOLD_MASK;
    end else if (interrupt_disable_count != '0) begin
      interrupt_disable_count <= interrupt_disable_count - 16'h0001;
    end
  end
  assign interrupts_held = (interrupt_disable_count != '0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_segment_ram_security   <= agm_pkg::RST_ZERO;
      secure_segment_ram_security <= agm_pkg::RST_ZERO;
    end else begin
      if (wr_to(agm_pkg::IDX_BOOT_RAM_SEC))
        boot_segment_ram_security <= pwdata[15:0] & agm_pkg::SEC_MASK;
      if (wr_to(agm_pkg::IDX_SEC_RAM_SEC))
        secure_segment_ram_security <= pwdata[15:0] & agm_pkg::SEC_MASK;
    end
  end

  // Read data is registered at setup so it is stable in the access phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= '0;
    end else if (apb_rd) begin
      case (idx)
        agm_pkg::IDX_CORE_STATUS:  prdata <= {16'h0000, core_status};
        agm_pkg::IDX_CORE_CONTROL: prdata <= {16'h0000, core_control};
        agm_pkg::IDX_CIRC_CONTROL: prdata <= {16'h0000, circular_bitrev_control};
        agm_pkg::IDX_X_BUF_START:  prdata <= {16'h0000, x_buffer_start};
        agm_pkg::IDX_X_BUF_END:    prdata <= {16'h0000, x_buffer_end};
        agm_pkg::IDX_Y_BUF_START:  prdata <= {16'h0000, y_buffer_start};
        agm_pkg::IDX_Y_BUF_END:    prdata <= {16'h0000, y_buffer_end};
        agm_pkg::IDX_BITREV_MOD:   prdata <= {16'h0000, bit_reverse_modifier};
        agm_pkg::IDX_HOLD_COUNT:   prdata <= {16'h0000, interrupt_disable_count};
        agm_pkg::IDX_BOOT_RAM_SEC: prdata <= {16'h0000, boot_segment_ram_security};
        agm_pkg::IDX_SEC_RAM_SEC:  prdata <= {16'h0000, secure_segment_ram_security};
        agm_pkg::IDX_UNIT_STATUS:  prdata <= {16'h0000, unit_status};
        default:                   prdata <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Circular mode decode
  // ---------------------------------------------------------------
  logic [3:0] x_circular_pointer_select;
  logic [3:0] y_circular_pointer_select;
  logic [3:0] bitrev_pointer_select;
  logic       x_circular_enable;
  logic       y_circular_enable;
  logic       bitrev_enable;
  logic       x_circ_on;
  logic       y_circ_on;

  assign x_circular_pointer_select = circular_bitrev_control[agm_pkg::XSEL_LSB +: 4];
  assign y_circular_pointer_select = circular_bitrev_control[agm_pkg::YSEL_LSB +: 4];
  assign bitrev_pointer_select     = circular_bitrev_control[agm_pkg::BSEL_LSB +: 4];
  assign x_circular_enable         = circular_bitrev_control[agm_pkg::XEN_BIT];
  assign y_circular_enable         = circular_bitrev_control[agm_pkg::YEN_BIT];
  assign bitrev_enable             = bit_reverse_modifier[agm_pkg::BREV_BIT];

  assign x_circ_on = x_circular_enable && (x_circular_pointer_select != agm_pkg::SEL_OFF);
  assign y_circ_on = y_circular_enable && (y_circular_pointer_select != agm_pkg::SEL_OFF);

  // ---------------------------------------------------------------
  // Effective address calculation
  // ---------------------------------------------------------------
  logic          is_mac;
  logic          y_unit;
  logic          illegal;
  logic [AW-1:0] step;
  logic          step_neg;
  logic [AW-1:0] base_ea;
  logic [AW-1:0] mod_ptr;
  logic [AW-1:0] circ_in;
  logic [AW-1:0] circ_out;
  logic          circ_sel;
  logic          bitrev_hit;

  assign is_mac   = (req.iclass == agm_pkg::AGM_CLS_MAC);
  assign y_unit   = is_mac && (req.ptr_sel == agm_pkg::REG_WORK_10 ||
                               req.ptr_sel == agm_pkg::REG_WORK_11);
  assign step     = AW'(req.modifier);
  assign step_neg = req.modifier[15];

  // Legality of the mode for the instruction class
  always_comb begin
    illegal = 1'b0;
    if (is_mac) begin
      if (req.is_write || req.ptr_sel < agm_pkg::REG_WORK_8 || req.ptr_sel > agm_pkg::REG_WORK_11)
        illegal = 1'b1;
      case (req.mode)
        agm_pkg::AGM_MODE_IND: ;
        agm_pkg::AGM_MODE_POST:
          if (req.modifier != 16'h0002 && req.modifier != 16'h0004 &&
              req.modifier != 16'h0006) illegal = 1'b1;
        agm_pkg::AGM_MODE_REG_OFS:
          if (req.ptr_sel != agm_pkg::REG_WORK_9 && req.ptr_sel != agm_pkg::REG_WORK_11)
            illegal = 1'b1;
        default: illegal = 1'b1;
      endcase
    end else if (req.mode == agm_pkg::AGM_MODE_REG_OFS &&
                 req.iclass != agm_pkg::AGM_CLS_MOVE) begin
      illegal = 1'b1;
    end
  end

  // Pointer arithmetic per mode
  always_comb begin
    base_ea = req.ptr_val;
    mod_ptr = req.ptr_val;
    case (req.mode)
      agm_pkg::AGM_MODE_FILE:    base_ea = AW'(req.file_addr);
      agm_pkg::AGM_MODE_LIT5:    base_ea = AW'(req.lit5);
      agm_pkg::AGM_MODE_DIRECT:  base_ea = req.ptr_val;
      agm_pkg::AGM_MODE_IND:     base_ea = req.ptr_val;
      agm_pkg::AGM_MODE_POST:    mod_ptr = AW'(req.ptr_val + step);
      agm_pkg::AGM_MODE_PRE: begin
        mod_ptr = AW'(req.ptr_val + step);
        base_ea = mod_ptr;
      end
      agm_pkg::AGM_MODE_REG_OFS: base_ea = AW'(req.ptr_val + req.ofs_val);
      agm_pkg::AGM_MODE_LIT_OFS: base_ea = AW'(req.ptr_val + req.ofs_val);
      default:                   base_ea = req.ptr_val;
    endcase
  end

  // Bit-reverse takes the X write path away from circular correction
  assign bitrev_hit = bitrev_enable && (bitrev_pointer_select != agm_pkg::SEL_OFF) &&
                      req.is_write && !req.prog_space &&
                      (req.ptr_sel == bitrev_pointer_select);

  // X buffer may serve W0 to W14, except W10 and W11 in the MAC class; Y buffer only W10 and W11 in the MAC class
  assign circ_sel = y_unit ? (y_circ_on && req.ptr_sel == y_circular_pointer_select)
                           : (x_circ_on && req.ptr_sel == x_circular_pointer_select &&
                              !bitrev_hit);
  assign circ_in  = (req.mode == agm_pkg::AGM_MODE_POST) ? mod_ptr : base_ea;

  agm_circ #(
    .AW (AW)
  ) u_circ (
    .addr      (circ_in),
    .step      (step),
    .step_neg  (step_neg),
    .buf_start (y_unit ? y_buffer_start : x_buffer_start),
    .buf_end   (y_unit ? y_buffer_end : x_buffer_end),
    .word_only (y_unit),
    .corrected (circ_out)
  );

  logic          ptr_mod_mode;
  logic          circ_apply;
  logic [AW-1:0] final_ea;
  logic [AW-1:0] final_wb;

  assign ptr_mod_mode = (req.mode == agm_pkg::AGM_MODE_PRE) ||
                        (req.mode == agm_pkg::AGM_MODE_POST);
  assign circ_apply   = circ_sel && (req.mode != agm_pkg::AGM_MODE_FILE) &&
                        (req.mode != agm_pkg::AGM_MODE_LIT5) &&
                        (req.mode != agm_pkg::AGM_MODE_DIRECT);

  always_comb begin
    final_ea = base_ea;
    final_wb = mod_ptr;
    if (circ_apply) begin
      if (req.mode == agm_pkg::AGM_MODE_POST) begin
        final_wb = circ_out;
      end else begin
        final_ea = circ_out;
        if (req.mode == agm_pkg::AGM_MODE_PRE) final_wb = circ_out;
      end
    end
    if (y_unit) final_ea = final_ea & agm_pkg::WORD_MASK;
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      resp <= '0;
    end else begin
      resp.valid       <= req.valid;
      resp.illegal     <= req.valid && illegal;
      resp.y_unit      <= y_unit;
      resp.use_default <= (req.mode == agm_pkg::AGM_MODE_FILE);
      resp.is_literal  <= (req.mode == agm_pkg::AGM_MODE_LIT5);
      resp.ea          <= final_ea;
      resp.wb_en       <= req.valid && !illegal && ptr_mod_mode;
      resp.wb_sel      <= req.ptr_sel;
      resp.wb_val      <= final_wb;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      branch_offset <= '0;
    end else begin
      branch_offset <= AW'($signed(branch_literal));
    end
  end

  // Last request outcome, visible to software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      unit_status <= '0;
    end else if (req.valid) begin
      unit_status <= {12'h000, circ_apply, bitrev_hit, y_unit, illegal};
    end
  end
endmodule : agm_top

// ### sim/agm_decoder_model.sv
// Decoder and working register file model that issues address requests
`timescale 1ns/1ps
module agm_decoder_model (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                go,
  input  wire logic                ld,
  input  wire logic                wr,
  input  wire agm_pkg::agm_class_t cls,
  input  wire agm_pkg::agm_mode_t  mode,
  input  wire logic [3:0]          sel,
  input  wire logic [15:0]         step,
  input  wire logic [15:0]         ofs,
  input  wire agm_pkg::agm_resp_t  resp,
  output      agm_pkg::agm_req_t   req
);
  logic [15:0] wfile [16];
  // Pointers are loaded with any ofs value on ld, otherwise from an enabled write-back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        wfile[i] <= 16'h0000;
      end
    end else if (ld) begin
      wfile[sel] <= ofs;
    end else if (resp.valid && resp.wb_en) begin
      wfile[resp.wb_sel] <= resp.wb_val;
    end
  end
  assign req = '{go, cls, mode, wr, 1'b0, sel, wfile[sel], ofs, step, ofs[12:0], ofs[4:0]};
endmodule : agm_decoder_model

// ### sim/agm_top_monitor.sv
// Port checker for the address generation unit
`timescale 1ns/1ps
module agm_top_monitor #(
  parameter int unsigned AW = 16
) (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire agm_pkg::agm_req_t  req,
  input wire agm_pkg::agm_resp_t resp,
  input wire logic [15:0]        branch_literal,
  input wire logic [AW-1:0]      branch_offset,
  input wire logic               hold_load,
  input wire logic [13:0]        hold_literal,
  input wire logic               interrupts_held
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic dual_v;
  assign dual_v = req.valid && req.iclass == agm_pkg::AGM_CLS_MAC;
  a_resp_one_cycle: assert property (resp.valid == $past(req.valid))
    else $error("response not one cycle after request");
  a_file_direct: assert property (req.valid && req.mode == agm_pkg::AGM_MODE_FILE
    |=> resp.use_default && resp.ea == {3'b000, $past(req.file_addr)})
    else $error("file address or implied register wrong");
  a_dual_reg_set: assert property (dual_v && !(req.ptr_sel inside {[8:11]})
    |=> resp.illegal && !resp.wb_en)
    else $error("prefetch pointer outside 8..11 accepted");
  a_dual_routing: assert property (dual_v && !req.is_write
    && (req.ptr_sel inside {[8:11]}) && req.mode == agm_pkg::AGM_MODE_IND
    |=> !resp.illegal && resp.y_unit == $past(req.ptr_sel[1]))
    else $error("prefetch pointer routed to wrong unit");
  a_dual_no_write: assert property (dual_v && req.is_write |=> resp.illegal)
    else $error("prefetch write accepted");
  a_dual_ofs_reg: assert property (dual_v && req.mode == agm_pkg::AGM_MODE_REG_OFS
    && !(req.ptr_sel inside {4'h9, 4'hB}) |=> resp.illegal)
    else $error("indexed prefetch on wrong pointer accepted");
  a_dual_step_set: assert property (dual_v && (req.mode == agm_pkg::AGM_MODE_PRE
    || (req.mode == agm_pkg::AGM_MODE_POST && !(req.modifier inside {16'h2, 16'h4, 16'h6})))
    |=> resp.illegal)
    else $error("prefetch modify step accepted");
  a_mcu_no_index: assert property (req.valid && req.iclass == agm_pkg::AGM_CLS_MCU
    && req.mode == agm_pkg::AGM_MODE_REG_OFS |=> resp.illegal)
    else $error("indexed mode accepted outside move class");
  a_offset_no_wb: assert property (req.valid && req.mode inside {agm_pkg::AGM_MODE_REG_OFS,
    agm_pkg::AGM_MODE_LIT_OFS} |=> !resp.wb_en)
    else $error("offset mode wrote pointer back");
  a_post_raw_ea: assert property (req.valid && req.iclass == agm_pkg::AGM_CLS_MCU
    && req.mode == agm_pkg::AGM_MODE_POST |=> resp.ea == $past(req.ptr_val) && resp.wb_en)
    else $error("post modify address not the pointer");
  a_branch_copy: assert property (branch_offset == $past(branch_literal))
    else $error("branch literal not passed through");
  a_hold_load: assert property (hold_load |=> interrupts_held == ($past(hold_literal) != 0))
    else $error("interrupt hold level wrong after load");
endmodule : agm_top_monitor

// ### sim/agm_top_tb.sv
// Self-checking bench for the address generation unit
`timescale 1ns/1ps
module agm_top_tb;
  localparam int unsigned AW = 16;
  localparam logic [31:0] CC = 32'h110, MC = 32'h118, XS = 32'h120, XE = 32'h128;
  localparam logic [31:0] YS = 32'h130, YE = 32'h138, DC = 32'h148;
  localparam agm_pkg::agm_class_t MCU = agm_pkg::AGM_CLS_MCU, DUAL = agm_pkg::AGM_CLS_MAC;
  localparam agm_pkg::agm_mode_t IND = agm_pkg::AGM_MODE_IND, POST = agm_pkg::AGM_MODE_POST;
  logic                core_clk, rst, psel, penable, pwrite, pready, pslverr, go, ld;
  logic                hold_load, interrupts_held, wr;
  logic [31:0]         paddr, pwdata, prdata;
  logic [15:0]         branch_literal, step, ofs, p;
  logic [AW-1:0]       branch_offset;
  logic [13:0]         hold_literal;
  logic [3:0]          sel;
  agm_pkg::agm_class_t cls;
  agm_pkg::agm_mode_t  mode;
  agm_pkg::agm_req_t   req;
  agm_pkg::agm_resp_t  resp;
  int                  mismatches = 0, n_compared = 0, cyc = 0;
  agm_top #(.AW(AW)) i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req(req), .resp(resp), .branch_literal(branch_literal),
    .branch_offset(branch_offset), .hold_load(hold_load), .hold_literal(hold_literal),
    .interrupts_held(interrupts_held));
  agm_decoder_model i_dec (.core_clk(core_clk), .rst(rst), .go(go), .ld(ld), .wr(wr), .cls(cls),
    .mode(mode), .sel(sel), .step(step), .ofs(ofs), .resp(resp), .req(req));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // -----------------------------------
  // Shared tasks
  // -----------------------------------
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d, x, input logic xe);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    if (!w) chk(prdata, x);
    chk(pslverr, xe);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic setp(input logic [3:0] s, input logic [15:0] v);
    @(posedge core_clk);
    ld <= 1'b1;
    sel <= s;
    ofs <= v;
    @(posedge core_clk);
    ld <= 1'b0;
  endtask : setp
  task automatic op(input agm_pkg::agm_class_t c, input agm_pkg::agm_mode_t m,
      input logic [3:0] s, input logic [15:0] st, o, input logic il, y,
      input logic [15:0] ea, input logic we, input logic [15:0] wv);
    @(posedge core_clk);
    go <= 1'b1;
    cls <= c;
    mode <= m;
    sel <= s;
    step <= st;
    ofs <= o;
    @(posedge core_clk);
    go <= 1'b0;
    #1;
    chk(resp.valid, 1'b1);
    chk(resp.illegal, il);
    if (!il) begin
      chk(resp.y_unit, y);
      chk(resp.ea, ea);
      chk(resp.wb_en, we);
      if (we) chk(resp.wb_val, wv);
    end
  endtask : op
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // -----------------------------------
  // Test sequence
  // -----------------------------------
  initial begin
    {rst, psel, penable, pwrite, go, ld, hold_load, wr} = 8'h80;
    {paddr, pwdata, branch_literal, step, ofs, hold_literal, sel} = '0;
    cls = MCU;
    mode = IND;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    bus(0, CC, 0, 32'h20, 0);
    bus(0, XE, 0, 32'h1, 0);
    bus(0, 32'h200, 0, 0, 1);
    bus(1, MC, 32'hFFFF, 0, 0);
    bus(0, MC, 0, 32'hCFFF, 0);
    bus(1, XS, 32'h1001, 0, 0);
    bus(0, XS, 0, 32'h1000, 0);
    bus(1, XE, 32'h100E, 0, 0);
    bus(0, XE, 0, 32'h100F, 0);
    bus(1, DC, 32'hFFFF, 0, 0);
    bus(0, DC, 0, 32'h3FFE, 0);
    $display("register test done");
    bus(1, MC, 32'h80F2, 0, 0);
    setp(2, 16'h100E);
    op(MCU, POST, 2, 2, 0, 0, 0, 16'h100E, 1, 16'h1000);
    op(MCU, agm_pkg::AGM_MODE_PRE, 2, 16'hFFFE, 0, 0, 0, 16'h100E, 1, 16'h100E);
    op(MCU, POST, 2, 6, 0, 0, 0, 16'h100E, 1, 16'h1004);
    op(agm_pkg::AGM_CLS_MOVE, agm_pkg::AGM_MODE_LIT_OFS, 2, 0, 16'hE, 0, 0, 16'h1002, 0, 0);
    op(agm_pkg::AGM_CLS_MOVE, agm_pkg::AGM_MODE_REG_OFS, 2, 0, 2, 0, 0, 16'h1006, 0, 0);
    op(MCU, agm_pkg::AGM_MODE_REG_OFS, 2, 0, 2, 1, 0, 0, 0, 0);
    for (int i = 0; i < 2; i++) begin
      bus(1, MC, i == 0 ? 32'h80FF : 32'h00F2, 0, 0);
      setp(2, 16'h100E);
      op(MCU, POST, 2, 2, 0, 0, 0, 16'h100E, 1, 16'h1010);
    end
    bus(1, 32'h140, 32'h8000, 0, 0);
    bus(1, MC, 32'h82F2, 0, 0);
    setp(2, 16'h100E);
    wr <= 1'b1;
    op(MCU, POST, 2, 2, 0, 0, 0, 16'h100E, 1, 16'h1010);
    op(DUAL, IND, 10, 0, 0, 1, 0, 0, 0, 0);
    @(posedge core_clk);
    wr <= 1'b0;
    $display("x buffer test done");
    bus(1, YS, 32'h2000, 0, 0);
    bus(1, YE, 32'h2007, 0, 0);
    bus(1, MC, 32'h40AF, 0, 0);
    setp(10, 16'h2006);
    op(DUAL, POST, 10, 2, 0, 0, 1, 16'h2006, 1, 16'h2000);
    setp(10, 16'h2003);
    op(DUAL, IND, 10, 0, 0, 0, 1, 16'h2002, 0, 0);
    for (int r = 0; r < 16; r++) begin
      if (r < 8 || r > 11) op(DUAL, IND, 4'(r), 0, 0, 1, 0, 0, 0, 0);
    end
    setp(11, 16'h2004);
    op(DUAL, IND, 11, 0, 0, 0, 1, 16'h2004, 0, 0);
    setp(8, 16'h0800);
    p = 16'h0800;
    for (int k = 1; k <= 4; k++) begin
      op(DUAL, POST, 8, 16'(2 * k), 0, k == 4, 0, p, 1, p + 16'(2 * k));
      p = p + 16'(2 * k);
    end
    op(DUAL, agm_pkg::AGM_MODE_PRE, 8, 2, 0, 1, 0, 0, 0, 0);
    setp(9, 16'h0900);
    op(DUAL, agm_pkg::AGM_MODE_REG_OFS, 9, 0, 4, 0, 0, 16'h0904, 0, 0);
    op(DUAL, agm_pkg::AGM_MODE_REG_OFS, 8, 0, 4, 1, 0, 0, 0, 0);
    $display("y unit test done");
    op(MCU, agm_pkg::AGM_MODE_FILE, 0, 0, 16'hFFFF, 0, 0, 16'h1FFF, 0, 0);
    chk(resp.use_default, 1'b1);
    op(MCU, agm_pkg::AGM_MODE_LIT5, 0, 0, 16'h1F, 0, 0, 16'h001F, 0, 0);
    chk(resp.is_literal, 1'b1);
    @(posedge core_clk);
    branch_literal <= 16'h8001;
    hold_load <= 1'b1;
    hold_literal <= 14'h0002;
    @(posedge core_clk);
    hold_load <= 1'b0;
    #1;
    chk(branch_offset, 16'h8001);
    chk(interrupts_held, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk(interrupts_held, 1'b0);
    $display("literal test done");
    tally_and_finish();
  end
endmodule : agm_top_tb
bind agm_top agm_top_monitor #(.AW(AW)) i_mon (.core_clk(core_clk), .rst(rst), .req(req),
  .resp(resp), .branch_literal(branch_literal), .branch_offset(branch_offset),
  .hold_load(hold_load), .hold_literal(hold_literal), .interrupts_held(interrupts_held));
